// file: verilog/bss_consts.svh
// Offsets, field positions, reset values and scale constants of the buck set-point block.
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH
`define BSS_ADDR_W          8
`define BSS_DATA_W          8
`define BSS_OFS_NORMAL      8'h00
`define BSS_OFS_STANDBY     8'h01
`define BSS_OFS_SLEEP       8'h02
`define BSS_OFS_STATUS      8'h03
`define BSS_CODE_W          7
`define BSS_FIELD_W         6
`define BSS_RANGE_POS       6
`define BSS_RST_FIELD       6'h00
`define BSS_LOW_BASE_MV     16'd400
`define BSS_LOW_STEP_MV     16'd25
`define BSS_HIGH_BASE_MV    16'd800
`define BSS_HIGH_STEP_MV    16'd50
`define BSS_MIN_OK_MV       16'd600
`endif

// file: verilog/bss_pkg.sv
// Types shared by the buck set-point block.
package bss_pkg;
  typedef enum logic [2:0] {
    BSS_MODE_NORMAL  = 3'b001,
    BSS_MODE_STANDBY = 3'b010,
    BSS_MODE_SLEEP   = 3'b100
  } bss_mode_e;

  typedef struct packed {
    logic       range_sel;
    logic [5:0] field;
  } bss_code_s;

  typedef logic [15:0] bss_mv_t;
endpackage : bss_pkg

// file: verilog/bss_top.sv
// Set-point selection logic of the second buck regulator.
//
// Summary of operation
// (R1) The range-select bit of the normal code is read-only to software.
// (R2) Range bit loads from default configuration; only the one-time store alters it.
// (R3) Range 0: 0.400 V plus 25 mV per count, up to 1.975 V.
// (R4) Range 1: 0.800 V plus 50 mV per count, up to 3.950 V.
// (R5) Three separate six-bit fields; the current mode's field is applied.
// (R6) Standby and sleep codes carry a copy of the normal range bit.
// (R7) Software should use the high range only for 2.000 V to 3.300 V.
// (R8) Software must not program outputs of 0.6 V or below.
// (R9) Writes to any range bit are ignored; reads return its value.
`timescale 1ns/1ps
`include "bss_consts.svh"

module bss_top (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  // Register port
  input  wire logic [`BSS_ADDR_W-1:0]  reg_addr,
  input  wire logic [`BSS_DATA_W-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`BSS_DATA_W-1:0]  reg_rdata,
  // Configuration
  input  wire logic                    cfg_default_range,
  input  wire logic                    otp_range_load,
  input  wire logic                    otp_range_value,
  // Operating mode
  input  wire bss_pkg::bss_mode_e      op_mode,
  // Converter set point
  output bss_pkg::bss_code_s           active_code,
  output bss_pkg::bss_mv_t             target_mv,
  output logic                         target_unsupported
);

  // ----------------------------------------------------------------
  // Range-select bit
  // ----------------------------------------------------------------
  // The default level is taken on the clocked reset, so the strap is never
  // sampled asynchronously. Only the one-time store can change it later.
  logic range_sel_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      range_sel_ff <= cfg_default_range; // R2
    end else if (otp_range_load) begin
      range_sel_ff <= otp_range_value; // R2
    end
  end

  // ----------------------------------------------------------------
  // Set-point fields
  // ----------------------------------------------------------------
  logic [`BSS_FIELD_W-1:0] field_ff [3];
  logic [`BSS_ADDR_W-1:0]  ofs_list [3];

  assign ofs_list[0] = `BSS_OFS_NORMAL;
  assign ofs_list[1] = `BSS_OFS_STANDBY;
  assign ofs_list[2] = `BSS_OFS_SLEEP;

  for (genvar i = 0; i < 3; i++) begin : g_field
    // Only the low six bits are stored; bit 6 of the write is dropped.
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        field_ff[i] <= `BSS_RST_FIELD;
      end else if (reg_wr && reg_addr == ofs_list[i]) begin
        field_ff[i] <= reg_wdata[`BSS_FIELD_W-1:0]; // R5 R1 R9
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [`BSS_DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    unique case (reg_addr)
      `BSS_OFS_NORMAL:  nxt_rdata = {1'b0, range_sel_ff, field_ff[0]}; // R9
      `BSS_OFS_STANDBY: nxt_rdata = {1'b0, range_sel_ff, field_ff[1]}; // R6
      `BSS_OFS_SLEEP:   nxt_rdata = {1'b0, range_sel_ff, field_ff[2]}; // R6
      `BSS_OFS_STATUS:  nxt_rdata = {5'h00, target_unsupported, range_sel_ff, 1'b0};
      default:          nxt_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? nxt_rdata : '0;
    end
  end

  // ----------------------------------------------------------------
  // Mode selection and voltage mapping
  // ----------------------------------------------------------------
  logic [`BSS_FIELD_W-1:0] sel_field;
  bss_pkg::bss_mv_t        nxt_mv;

  always_comb begin
    unique case (op_mode)
      bss_pkg::BSS_MODE_NORMAL:  sel_field = field_ff[0]; // R5
      bss_pkg::BSS_MODE_STANDBY: sel_field = field_ff[1]; // R5
      bss_pkg::BSS_MODE_SLEEP:   sel_field = field_ff[2]; // R5
      default:                   sel_field = field_ff[0];
    endcase
  end

  always_comb begin
    if (range_sel_ff) begin
      nxt_mv = `BSS_HIGH_BASE_MV + 16'(sel_field) * `BSS_HIGH_STEP_MV; // R4
    end else begin
      nxt_mv = `BSS_LOW_BASE_MV + 16'(sel_field) * `BSS_LOW_STEP_MV; // R3
    end
  end

  // The unsupported flag only reports; the converter is not blocked, since
  // keeping to the supported span is left to software.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_code        <= '0;
      target_mv          <= '0;
      target_unsupported <= 1'b0;
    end else begin
      active_code        <= '{range_sel: range_sel_ff, field: sel_field}; // R6
      target_mv          <= nxt_mv;
      target_unsupported <= (nxt_mv <= `BSS_MIN_OK_MV); // R8
    end
  end

endmodule : bss_top

// file: tb/bss_checker.sv
// Port assertions for the buck set-point block.
`timescale 1ns/1ps
module bss_checker (
  input wire logic               sys_clk, srst, reg_wr, reg_rd, cfg_default_range,
  input wire logic               otp_range_load, otp_range_value, target_unsupported,
  input wire logic [7:0]         reg_addr, reg_wdata, reg_rdata,
  input wire bss_pkg::bss_mode_e op_mode,
  input wire bss_pkg::bss_code_s active_code,
  input wire bss_pkg::bss_mv_t   target_mv
);
  logic [1:0] up_ff;
  // Outputs lag reset release by one edge, so checks wait two.
  always_ff @(posedge sys_clk) up_ff <= srst ? 2'h0 : {up_ff[0], 1'b1};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst || !up_ff[1]);
  AST_LOW: assert property (!active_code.range_sel |-> target_mv == 16'd400 + 16'd25 * active_code.field)
    else $error("low range target wrong");
  AST_HIGH: assert property (active_code.range_sel |-> target_mv == 16'd800 + 16'd50 * active_code.field)
    else $error("high range target wrong");
  AST_RO: assert property (!$past(otp_range_load) && !$past(otp_range_load, 2) |-> $stable(active_code.range_sel))
    else $error("range bit changed without load");
  AST_LOAD: assert property (otp_range_load |-> ##2 active_code.range_sel == $past(otp_range_value, 2))
    else $error("range bit not loaded");
  AST_COPY: assert property (reg_rd && reg_addr inside {8'h01, 8'h02} && !otp_range_load
    && !$past(otp_range_load) |=> reg_rdata[6] == active_code.range_sel)
    else $error("copied range bit differs");
  AST_WRRO: assert property (reg_wr && !otp_range_load ##1 reg_rd && !otp_range_load |=> !reg_rdata[7])
    else $error("top bit reads one");
  AST_MODE: assert property ($stable(op_mode) && $stable(active_code) |-> $stable(target_mv))
    else $error("target moved without cause");
  C_SLEEP: cover property (op_mode == bss_pkg::BSS_MODE_SLEEP && active_code.field != 6'h00);
  C_LOAD: cover property (otp_range_load);
  C_READ: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : bss_checker
bind bss_top bss_checker u_chk (.*);

// file: tb/testbench.sv
// Self-checking bench for the buck set-point block.
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, cfg_default_range = 1;
  logic otp_range_load = 0, otp_range_value = 0, target_unsupported;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  bss_pkg::bss_mode_e op_mode = bss_pkg::BSS_MODE_NORMAL;
  bss_pkg::bss_code_s active_code;
  bss_pkg::bss_mv_t   target_mv;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  bss_top DUT (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin num_errors++; close_out(); end
  end
  task automatic chk(string n, logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin num_errors++; $display("unexpected %s exp %h got %h", n, e, s); end
  endtask : chk
  task automatic wr(logic [7:0] a, d);
    @(posedge sys_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1; end
    @(posedge sys_clk) reg_wr <= 0;
  endtask : wr
  task automatic rd(logic [7:0] a, e);
    @(posedge sys_clk) begin reg_addr <= a; reg_rd <= 1; end
    @(posedge sys_clk) reg_rd <= 0;
    @(negedge sys_clk) chk("reg_rdata", reg_rdata, e);
    @(negedge sys_clk) chk("reg_rdata_idle", reg_rdata, 0);
  endtask : rd
  task automatic wrrd(logic [7:0] a, d, e);
    @(posedge sys_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1; end
    @(posedge sys_clk) begin reg_wr <= 0; reg_rd <= 1; end
    @(posedge sys_clk) reg_rd <= 0;
    @(negedge sys_clk) chk("reg_rdata_b2b", reg_rdata, e);
  endtask : wrrd
  task automatic mode(bss_pkg::bss_mode_e m, logic [6:0] c, logic [15:0] mv);
    @(posedge sys_clk) op_mode <= m;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk("active_code", active_code, c);
    chk("target_mv", target_mv, mv);
  endtask : mode
  task automatic t_range();
    rd(8'h00, 8'h40);
    wrrd(8'h00, 8'hFF, 8'h7F);
    wr(8'h00, 8'h32);
    rd(8'h00, 8'h72);
    chk("target_mv", target_mv, 16'd3300);
  endtask : t_range
  task automatic t_modes();
    wr(8'h01, 8'hC8);
    wr(8'h02, 8'h01);
    rd(8'h01, 8'h48);
    mode(bss_pkg::BSS_MODE_STANDBY, 7'h48, 16'd1200);
    mode(bss_pkg::BSS_MODE_SLEEP, 7'h41, 16'd850);
  endtask : t_modes
  task automatic t_otp();
    @(posedge sys_clk) otp_range_load <= 1;
    @(posedge sys_clk) otp_range_load <= 0;
    mode(bss_pkg::BSS_MODE_SLEEP, 7'h01, 16'd425);
    chk("target_unsupported", target_unsupported, 1);
    rd(8'h03, 8'h04);
    mode(bss_pkg::BSS_MODE_NORMAL, 7'h32, 16'd1650);
    rd(8'h02, 8'h01);
  endtask : t_otp
  task automatic t_reset();
    @(posedge sys_clk) begin srst <= 1; cfg_default_range <= 0; end
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    @(negedge sys_clk) chk("active_code_rst", active_code, 0);
    chk("target_mv_rst", target_mv, 0);
    rd(8'h00, 8'h00);
    mode(bss_pkg::BSS_MODE_NORMAL, 7'h00, 16'd400);
    chk("target_unsupported", target_unsupported, 1);
  endtask : t_reset
  task automatic close_out();
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    t_range();
    t_modes();
    t_otp();
    t_reset();
    close_out();
  end
endmodule : testbench
